// [core/tcd_pkg.sv]
// constants shared by the timer command decoder files
`default_nettype none
package tcd_pkg;
    localparam int NUM_CTR = 5;
    localparam int CTR_W = 16;
    // opcode groups in the top three command bits
    localparam logic [2:0] OP_DPTR = 3'h0;
    localparam logic [2:0] OP_ARM = 3'h1;
    localparam logic [2:0] OP_LOAD = 3'h2;
    localparam logic [2:0] OP_LDARM = 3'h3;
    localparam logic [2:0] OP_DISSAVE = 3'h4;
    localparam logic [2:0] OP_SAVE = 3'h5;
    localparam logic [2:0] OP_DISARM = 3'h6;
    localparam logic [2:0] OP_MISC = 3'h7;
    // single-bit master-mode commands, full 8-bit codes
    localparam logic [7:0] CMD_SEQ_OFF = 8'he8;
    localparam logic [7:0] CMD_SEQ_ON = 8'he0;
    localparam logic [7:0] CMD_FREQ_OFF = 8'hee;
    localparam logic [7:0] CMD_FREQ_ON = 8'he6;
    localparam logic [7:0] CMD_WIDE_ON = 8'hef;
    localparam logic [7:0] CMD_WIDE_OFF = 8'he7;
    // sub-opcodes in bits 4:3 of the misc group
    localparam logic [1:0] SUB_CLR_TOG = 2'h0;
    localparam logic [1:0] SUB_SET_TOG = 2'h1;
    localparam logic [1:0] SUB_STEP = 2'h2;
    // master-mode bit positions
    localparam int MM_SEQ_OFF_POS = 14;
    localparam int MM_WIDE_POS = 13;
    localparam int MM_FREQ_OFF_POS = 12;
    localparam logic [15:0] MM_RESET = 16'h0000;
    // counter-mode field positions
    localparam int CM_UP_POS = 3;
    localparam logic [2:0] OUT_TOGGLE = 3'h2;
    localparam logic [2:0] GRP_BAD0 = 3'h0;
    localparam logic [2:0] GRP_BAD6 = 3'h6;
    localparam logic [5:0] DPTR_RESET = 6'h00;
    // avalon register map, byte addresses
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_MM = 4'h4;
    localparam logic [3:0] REG_DPTR = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hc;
endpackage : tcd_pkg
`default_nettype wire

// [core/tcd_cmd_decode.sv]
// decodes one 8-bit command into per-counter actions
`default_nettype none
module tcd_cmd_decode (
    input wire logic [7:0] i_cmd,
    output logic [4:0] o_load,
    output logic [4:0] o_arm,
    output logic [4:0] o_disarm,
    output logic [4:0] o_save,
    output logic [4:0] o_set_tog,
    output logic [4:0] o_clr_tog,
    output logic [4:0] o_step
);
    // counter number code to one-hot, codes outside 1..5 give none
    function automatic logic [4:0] tcd_num_sel(input logic [2:0] n);
        logic [4:0] r;
        r = 5'h00;
        if (n >= 3'h1 && n <= 3'h5) begin
            r[n - 3'h1] = 1'b1;
        end
        return r;
    endfunction : tcd_num_sel

    logic [2:0] op;
    logic [4:0] sel;
    logic [4:0] nsel;
    assign op = i_cmd[7:5];
    assign sel = i_cmd[4:0];
    assign nsel = tcd_num_sel(i_cmd[2:0]);

    // full 8-bit decode each write
    always_comb begin
        o_load = 5'h00;
        o_arm = 5'h00;
        o_disarm = 5'h00;
        o_save = 5'h00;
        o_set_tog = 5'h00;
        o_clr_tog = 5'h00;
        o_step = 5'h00;
        case (op)
            tcd_pkg::OP_ARM: o_arm = sel;
            tcd_pkg::OP_LOAD: o_load = sel;
            tcd_pkg::OP_LDARM: begin
                o_load = sel;
                o_arm = sel;
            end
            tcd_pkg::OP_DISSAVE: begin
                o_disarm = sel;
                o_save = sel;
            end
            tcd_pkg::OP_SAVE: o_save = sel;
            tcd_pkg::OP_DISARM: o_disarm = sel;
            tcd_pkg::OP_MISC: begin
                // bit 2:0 of 000/110/111 collide with mm commands; nsel is empty then
                case (i_cmd[4:3])
                    tcd_pkg::SUB_SET_TOG: o_set_tog = nsel;
                    tcd_pkg::SUB_CLR_TOG: o_clr_tog = nsel;
                    tcd_pkg::SUB_STEP: o_step = nsel;
                    default: o_step = 5'h00;
                endcase
            end
            default: o_load = 5'h00;
        endcase
    end
endmodule : tcd_cmd_decode
`default_nettype wire

// [core/tcd_counter.sv]
// one counter: count, hold, armed, terminal count and toggle state
`default_nettype none
module tcd_counter (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_src_edge,
    input wire logic i_gate,
    input wire logic i_load,
    input wire logic i_arm,
    input wire logic i_disarm,
    input wire logic i_save,
    input wire logic i_set_tog,
    input wire logic i_clr_tog,
    input wire logic i_step,
    input wire logic [15:0] i_load_val,
    input wire logic [15:0] i_hold_wr_val,
    input wire logic i_hold_wr,
    input wire logic [15:0] i_mode,
    input wire logic i_alt_mode,
    input wire logic i_tc_disarm_mode,
    output logic [15:0] o_count,
    output logic [15:0] o_hold,
    output logic o_armed,
    output logic o_tc,
    output logic o_toggle,
    output logic o_out
);
    logic [15:0] count_q;
    logic [15:0] hold_q;
    logic armed_q;
    logic tc_q;
    logic tog_q;
    logic pend_dis_q;
    logic use_hold_q;
    logic up;
    logic tick;
    logic leaving_tc;
    logic at_end;
    logic [15:0] nxt;

    assign up = i_mode[tcd_pkg::CM_UP_POS];
    assign tick = i_src_edge && armed_q && i_gate;
    assign nxt = up ? count_q + 16'h0001 : count_q - 16'h0001;
    assign at_end = up ? (count_q == 16'hffff) : (count_q == 16'h0001);
    // any count event takes the counter out of terminal count
    assign leaving_tc = tc_q && (tick || i_load || i_step || (i_src_edge && pend_dis_q));

    // armed state; load-and-arm cancels a deferred disarm
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            armed_q <= 1'b0;
            pend_dis_q <= 1'b0;
        end else if (i_arm) begin
            armed_q <= 1'b1;
            pend_dis_q <= 1'b0;
        end else if (i_disarm && tc_q && !leaving_tc) begin
            pend_dis_q <= 1'b1;
        end else if (i_disarm || (pend_dis_q && leaving_tc)) begin
            armed_q <= 1'b0;
            pend_dis_q <= 1'b0;
        end else if (tick && at_end && i_tc_disarm_mode) begin
            armed_q <= 1'b0;
        end
    end

    // count register: load, step and armed ticks
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            count_q <= 16'h0000;
            tc_q <= 1'b0;
            use_hold_q <= 1'b0;
        end else begin
            if (i_load) begin
                count_q <= (use_hold_q && armed_q) ? hold_q : i_load_val;
                tc_q <= 1'b0;
            end else if (i_step || tick || (pend_dis_q && i_src_edge && tc_q)) begin
                count_q <= nxt;
                tc_q <= at_end;
                if (at_end && i_alt_mode) begin
                    use_hold_q <= !use_hold_q;
                end
            end
            if (i_arm && i_alt_mode) begin
                use_hold_q <= 1'b1;
            end
        end
    end

    // hold register: save copies the live count
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            hold_q <= 16'h0000;
        end else if (i_save) begin
            hold_q <= count_q;
        end else if (i_hold_wr) begin
            hold_q <= i_hold_wr_val;
        end
    end

    // toggle flip-flop, set wins over clear
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tog_q <= 1'b0;
        end else if (i_set_tog) begin
            tog_q <= 1'b1;
        end else if (i_clr_tog) begin
            tog_q <= 1'b0;
        end else if (tick && at_end && !i_tc_disarm_mode) begin
            tog_q <= !tog_q;
        end
    end

    // toggle level only reaches the pin in toggle output mode
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_out <= 1'b0;
        end else begin
            o_out <= (i_mode[2:0] == tcd_pkg::OUT_TOGGLE) ? tog_q : tc_q;
        end
    end

    assign o_count = count_q;
    assign o_hold = hold_q;
    assign o_armed = armed_q;
    assign o_tc = tc_q;
    assign o_toggle = tog_q;

    arm_sets_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_arm |=> armed_q) else $error("arm did not arm");
    disarm_stop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_disarm && !i_arm && !tc_q) |=> !armed_q) else $error("disarm ignored");
    // an already disarmed counter stays disarmed, only the pending flag is new
    tc_defer_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_disarm && !i_arm && tc_q && !leaving_tc)
        |=> pend_dis_q && armed_q == $past(armed_q))
        else $error("disarm at tc not deferred");
    tc_self_disarm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (tick && at_end && i_tc_disarm_mode && !i_arm) |=> !armed_q)
        else $error("no disarm at terminal count");
    save_copy_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_save |=> hold_q == $past(count_q)) else $error("save lost value");
    step_dir_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_step && !i_load) |=> count_q == ($past(up) ? $past(count_q) + 16'h0001
        : $past(count_q) - 16'h0001)) else $error("step wrong");
    load_end_tc_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_load && tc_q) |=> !tc_q) else $error("load kept tc");
    // output lags the flip-flop by one register stage
    set_tog_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_set_tog |=> tog_q ##1 (o_out == $past(tog_q)
        || $past(i_mode[2:0]) != tcd_pkg::OUT_TOGGLE)) else $error("toggle set failed");
endmodule : tcd_counter
`default_nettype wire

// [core/tcd_top.sv]
// timer command decoder with avalon-mm register access
// What this block does
// - load-and-arm loads then arms selected counters
// - arm part re-enables counting after terminal count
// - load-and-arm makes next reload from hold
// - disarm stops counting on selected counters
// - at terminal count, one more count first
// - disarmed counter still loads, saves, re-arms
// - save copies count into hold register
// - disarm-and-save disarms then saves
// - set-toggle drives counter N toggle high
// - clear-toggle drives counter N toggle low
// - toggle reaches output only in toggle mode
// - step counts down or up by direction bit
// - step works on disarmed counters too
// - pointer load copies element, group, sets byte bit
// - pointer updates only for legal group codes
// - sequencing-off command sets bit 14
// - sequencing-on command clears bit 14
// - wide-bus command sets bit 13
// - narrow-bus command clears bit 13
// - gate-off sets bit 12, output low
// - full master-mode write also sets these bits
// - arm only enables, zero select keeps state
// - load at terminal count ends terminal count
`default_nettype none
module tcd_top (
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    input wire logic [3:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic [4:0] I_SRC_EDGE,
    input wire logic [4:0] I_GATE,
    input wire logic I_FREQ_SRC,
    output logic O_FREQUENCY_OUTPUT,
    output logic [4:0] O_CTR_OUT,
    output logic O_WIDE_BUS,
    output logic O_SEQ_OFF
);
    logic [15:0] mm_q;
    logic [5:0] dptr_q;
    logic [15:0] load_val_q [tcd_pkg::NUM_CTR];
    logic [15:0] mode_q [tcd_pkg::NUM_CTR];
    logic ack_q;
    logic cmd_stb;
    logic [7:0] cmd;
    logic [4:0] d_load, d_arm, d_disarm, d_save, d_set, d_clr, d_step;
    logic [15:0] cnt [tcd_pkg::NUM_CTR];
    logic [15:0] hold [tcd_pkg::NUM_CTR];
    logic [4:0] armed, tc, tog, ctr_out;
    logic [2:0] grp;

    // one wait state: every access answers on the second edge
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (I_AVS_READ || I_AVS_WRITE) && !ack_q;
        end
    end
    assign O_AVS_WAITREQUEST = !ack_q;

    // command taken once per write, on the completing edge
    assign cmd_stb = I_AVS_WRITE && ack_q && (I_AVS_ADDRESS == tcd_pkg::REG_CMD);
    assign cmd = I_AVS_WRITEDATA[7:0];
    assign grp = cmd[2:0];

    tcd_cmd_decode u_dec (
        .i_cmd(cmd),
        .o_load(d_load),
        .o_arm(d_arm),
        .o_disarm(d_disarm),
        .o_save(d_save),
        .o_set_tog(d_set),
        .o_clr_tog(d_clr),
        .o_step(d_step)
    );

    // master-mode register: single-bit commands and full-word writes
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            mm_q <= tcd_pkg::MM_RESET;
        end else if (I_AVS_WRITE && ack_q && I_AVS_ADDRESS == tcd_pkg::REG_MM) begin
            mm_q <= I_AVS_WRITEDATA[15:0];
        end else if (cmd_stb) begin
            case (cmd)
                tcd_pkg::CMD_SEQ_OFF: mm_q[tcd_pkg::MM_SEQ_OFF_POS] <= 1'b1;
                tcd_pkg::CMD_SEQ_ON: mm_q[tcd_pkg::MM_SEQ_OFF_POS] <= 1'b0;
                tcd_pkg::CMD_WIDE_ON: mm_q[tcd_pkg::MM_WIDE_POS] <= 1'b1;
                tcd_pkg::CMD_WIDE_OFF: mm_q[tcd_pkg::MM_WIDE_POS] <= 1'b0;
                tcd_pkg::CMD_FREQ_OFF: mm_q[tcd_pkg::MM_FREQ_OFF_POS] <= 1'b1;
                tcd_pkg::CMD_FREQ_ON: mm_q[tcd_pkg::MM_FREQ_OFF_POS] <= 1'b0;
                default: mm_q <= mm_q;
            endcase
        end
    end

    // data pointer: element, group and byte bit; illegal groups ignored
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            dptr_q <= tcd_pkg::DPTR_RESET;
        end else if (cmd_stb && cmd[7:5] == tcd_pkg::OP_DPTR
                     && grp != tcd_pkg::GRP_BAD0 && grp != tcd_pkg::GRP_BAD6) begin
            dptr_q <= {1'b1, cmd[4:0]};
        end
    end

    // per-counter load and mode registers, written by software
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            for (int k = 0; k < tcd_pkg::NUM_CTR; k++) begin
                load_val_q[k] <= 16'h0000;
                mode_q[k] <= 16'h0000;
            end
        end else if (I_AVS_WRITE && ack_q && I_AVS_ADDRESS[3:2] == 2'h3) begin
            load_val_q[dptr_q[2:0] == 3'h0 ? 0 : 32'(dptr_q[2:0] - 3'h1) % 5]
                <= I_AVS_WRITEDATA[15:0];
            mode_q[dptr_q[2:0] == 3'h0 ? 0 : 32'(dptr_q[2:0] - 3'h1) % 5]
                <= I_AVS_WRITEDATA[31:16];
        end
    end

    // five counters sharing the decoded strobes
    for (genvar g = 0; g < tcd_pkg::NUM_CTR; g++) begin : g_ctr
        tcd_counter u_ctr (
            .i_clk(I_REF_CLK),
            .i_rst_n(I_RESET_N),
            .i_src_edge(I_SRC_EDGE[g]),
            .i_gate(I_GATE[g]),
            .i_load(cmd_stb && d_load[g]),
            .i_arm(cmd_stb && d_arm[g]),
            .i_disarm(cmd_stb && d_disarm[g]),
            .i_save(cmd_stb && d_save[g]),
            .i_set_tog(cmd_stb && d_set[g]),
            .i_clr_tog(cmd_stb && d_clr[g]),
            .i_step(cmd_stb && d_step[g]),
            .i_load_val(load_val_q[g]),
            .i_hold_wr_val(16'h0000),
            .i_hold_wr(1'b0),
            .i_mode(mode_q[g]),
            .i_alt_mode(mode_q[g][15]),
            .i_tc_disarm_mode(mode_q[g][5]),
            .o_count(cnt[g]),
            .o_hold(hold[g]),
            .o_armed(armed[g]),
            .o_tc(tc[g]),
            .o_toggle(tog[g]),
            .o_out(ctr_out[g])
        );
    end

    // registered outputs; gate-off forces the frequency pin low
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            O_FREQUENCY_OUTPUT <= 1'b0;
            O_CTR_OUT <= 5'h00;
            O_WIDE_BUS <= 1'b0;
            O_SEQ_OFF <= 1'b0;
        end else begin
            O_FREQUENCY_OUTPUT <= I_FREQ_SRC && !mm_q[tcd_pkg::MM_FREQ_OFF_POS];
            O_CTR_OUT <= ctr_out;
            O_WIDE_BUS <= mm_q[tcd_pkg::MM_WIDE_POS];
            O_SEQ_OFF <= mm_q[tcd_pkg::MM_SEQ_OFF_POS];
        end
    end

    // read mux, registered so data stands at the completing edge
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            O_AVS_READDATA <= 32'h0000_0000;
        end else begin
            case (I_AVS_ADDRESS)
                tcd_pkg::REG_MM: O_AVS_READDATA <= {16'h0000, mm_q};
                tcd_pkg::REG_DPTR: O_AVS_READDATA <= {26'h0, dptr_q};
                tcd_pkg::REG_STAT: O_AVS_READDATA <= {17'h0, tog, tc, armed};
                default: O_AVS_READDATA <= {cnt[0], hold[0]};
            endcase
        end
    end

    mm_seq_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
        (cmd_stb && cmd == tcd_pkg::CMD_SEQ_OFF) |=> ##1 O_SEQ_OFF)
        else $error("seq off missing");
    mm_gate_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
        mm_q[tcd_pkg::MM_FREQ_OFF_POS] |=> !O_FREQUENCY_OUTPUT)
        else $error("frequency output not gated");
    dptr_bad_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RESET_N)
        (cmd_stb && cmd[7:5] == tcd_pkg::OP_DPTR
        && (grp == tcd_pkg::GRP_BAD0 || grp == tcd_pkg::GRP_BAD6))
        |=> $stable(dptr_q)) else $error("bad group loaded");
endmodule : tcd_top
`default_nettype wire

// [sim/tcd_host.sv]
// host model: avalon-mm master that issues commands and register accesses
`default_nettype none
module tcd_host (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_waitrequest,
    input wire logic [31:0] i_readdata,
    output logic [3:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [31:0] o_writedata
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle until the bench starts issuing requests after reset
    initial begin
        o_address = 4'h0;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h00000000;
    end

    // one command at a time, all on the host clock, which is the bench's free-running reference clock
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_address <= a;
        o_writedata <= d;
        o_write <= 1'b1;
        do @(posedge i_clk); while (i_waitrequest !== 1'b0);
        o_write <= 1'b0;
        // released lines show the inverse so stale values cannot pass
        o_address <= ~a;
        o_writedata <= ~d;
    endtask : wr

    // read data taken at the same edge that sees waitrequest low
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clk);
        o_address <= a;
        o_read <= 1'b1;
        do @(posedge i_clk); while (i_waitrequest !== 1'b0);
        d = i_readdata;
        o_read <= 1'b0;
        o_address <= ~a;
    endtask : rd
endmodule : tcd_host
`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the timer command decoder
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic rst_n;
    logic [3:0] addr;
    logic rd_en;
    logic wr_en;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wait_req;
    logic [4:0] src_edge;
    logic [4:0] gate;
    logic freq_src;
    logic freq_out;
    logic [4:0] ctr_out;
    logic wide;
    logic seq_off;
    int failures;
    int checks_done;
    logic [31:0] seed;
    logic [31:0] v;
    logic [31:0] s;
    logic [15:0] mm;
    logic [15:0] val;
    logic [4:0] exp5;
    logic [7:0] codes [8];

    // free-running reference clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    tcd_top u_tcd_top (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_AVS_ADDRESS(addr),
        .I_AVS_READ(rd_en), .I_AVS_WRITE(wr_en), .I_AVS_WRITEDATA(wdata),
        .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wait_req), .I_SRC_EDGE(src_edge),
        .I_GATE(gate), .I_FREQ_SRC(freq_src), .O_FREQUENCY_OUTPUT(freq_out),
        .O_CTR_OUT(ctr_out), .O_WIDE_BUS(wide), .O_SEQ_OFF(seq_off));

    tcd_host u_host (.i_clk(clk), .i_rst_n(rst_n), .i_waitrequest(wait_req),
        .i_readdata(rdata), .o_address(addr), .o_read(rd_en), .o_write(wr_en),
        .o_writedata(wdata));

    // counter picked by a three-bit number, none outside one to five
    function automatic logic [4:0] sel_of(input logic [2:0] n);
        return (n >= 3'h1 && n <= 3'h5) ? 5'h01 << (n - 3'h1) : 5'h00;
    endfunction : sel_of

    // master-mode word after a single-bit command, other bits kept
    function automatic logic [15:0] mm_after(input logic [15:0] m, input logic [7:0] c);
        case (c)
            tcd_pkg::CMD_SEQ_OFF: m[14] = 1'b1;
            tcd_pkg::CMD_SEQ_ON: m[14] = 1'b0;
            tcd_pkg::CMD_WIDE_ON: m[13] = 1'b1;
            tcd_pkg::CMD_WIDE_OFF: m[13] = 1'b0;
            tcd_pkg::CMD_FREQ_OFF: m[12] = 1'b1;
            tcd_pkg::CMD_FREQ_ON: m[12] = 1'b0;
            default: m = m;
        endcase
        return m;
    endfunction : mm_after

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cmd(input logic [7:0] c);
        u_host.wr(tcd_pkg::REG_CMD, {24'h000000, c});
    endtask : cmd

    task automatic rd(input logic [3:0] a);
        u_host.rd(a, v);
    endtask : rd

    // registered outputs lag the write by up to two cycles
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task automatic chk_mm;
        settle();
        rd(tcd_pkg::REG_MM);
        chk({16'h0000, v[15:0]}, {16'h0000, mm});
        chk({29'h0, wide, seq_off, freq_out}, {29'h0, mm[13], mm[14], ~mm[12] & freq_src});
    endtask : chk_mm

    // count of counter one sits in the upper half of an unmapped read
    task automatic cnt_is(input logic [15:0] c);
        rd(4'h1);
        chk({16'h0000, v[31:16]}, {16'h0000, c});
    endtask : cnt_is

    task automatic armed1_is(input logic a);
        rd(tcd_pkg::REG_STAT);
        chk({31'h0, v[0]}, {31'h0, a});
    endtask : armed1_is

    task automatic pulse;
        @(posedge clk);
        src_edge <= 5'h01;
        @(posedge clk);
        src_edge <= 5'h00;
        settle();
    endtask : pulse

    task automatic close_out;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    // watchdog far beyond the fewer than one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        close_out();
    end

    initial begin
        seed = 32'hbf7a833f;
        failures = 0;
        checks_done = 0;
        rst_n = 1'b0;
        src_edge = 5'h00;
        gate = 5'h1f;
        freq_src = 1'b1;
        codes = '{tcd_pkg::CMD_SEQ_OFF, tcd_pkg::CMD_WIDE_ON, tcd_pkg::CMD_FREQ_OFF, 8'hf8,
            tcd_pkg::CMD_SEQ_ON, tcd_pkg::CMD_WIDE_OFF, tcd_pkg::CMD_FREQ_ON, 8'hf9};
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        mm = tcd_pkg::MM_RESET;
        chk_mm();
        rd(tcd_pkg::REG_STAT);
        chk({22'h0, v[14:10], v[4:0]}, 32'h0);
        $display("test reset done");
        // full-word write first, then each single-bit command on top
        s = $random(seed);
        mm = s[15:0];
        u_host.wr(tcd_pkg::REG_MM, {16'h0000, mm});
        chk_mm();
        foreach (codes[i]) begin
            cmd(codes[i]);
            mm = mm_after(mm, codes[i]);
            chk_mm();
        end
        $display("test master mode done");
        // random arm and disarm masks; a counter in terminal count stays armed
        for (int i = 0; i < 12; i++) begin
            s = $random(seed);
            rd(tcd_pkg::REG_STAT);
            exp5 = s[5] ? v[4:0] | s[4:0] : v[4:0] & ~(s[4:0] & ~v[9:5]);
            cmd({s[5] ? tcd_pkg::OP_ARM : tcd_pkg::OP_DISARM, s[4:0]});
            rd(tcd_pkg::REG_STAT);
            chk({27'h0, v[4:0]}, {27'h0, exp5});
        end
        $display("test arm done");
        // every counter number set then cleared, illegal numbers touch no toggle
        for (int n = 0; n < 16; n++) begin
            rd(tcd_pkg::REG_STAT);
            exp5 = n[3] ? v[14:10] & ~sel_of(n[2:0]) : v[14:10] | sel_of(n[2:0]);
            cmd({3'h7, 1'b0, ~n[3], n[2:0]});
            rd(tcd_pkg::REG_STAT);
            chk({27'h0, v[14:10]}, {27'h0, exp5});
        end
        $display("test toggle done");
        // counter one: routing, toggle output, step, save, load-and-arm
        for (int k = 0; k < 3; k++) begin
            s = $random(seed);
            val = {2'h1, s[13:0]};
            cmd(8'h02);
            cmd(8'h01);
            cmd(8'h00);
            cmd(8'h06);
            u_host.wr(tcd_pkg::REG_STAT, {16'h0002, val});
            cmd(8'hc1);
            cmd(8'h41);
            cnt_is(val);
            cmd(8'he9);
            settle();
            chk({31'h0, ctr_out[0]}, 32'h1);
            cmd(8'he1);
            settle();
            chk({31'h0, ctr_out[0]}, 32'h0);
            u_host.wr(tcd_pkg::REG_STAT, {16'h0000, val});
            cmd(8'he9);
            settle();
            rd(tcd_pkg::REG_STAT);
            chk({31'h0, ctr_out[0]}, {31'h0, v[5]});
            cmd(8'hf1);
            cnt_is(val - 16'h0001);
            u_host.wr(tcd_pkg::REG_STAT, {16'h0008, val});
            cmd(8'hf1);
            cmd(8'hf1);
            cnt_is(val + 16'h0001);
            cmd(8'ha1);
            cnt_is(val + 16'h0001);
            chk({16'h0000, v[15:0]}, {16'h0000, val + 16'h0001});
            cmd(8'h61);
            cnt_is(val);
            armed1_is(1'b1);
            pulse();
            cnt_is(val + 16'h0001);
            cmd(8'h81);
            cnt_is(val + 16'h0001);
            chk({16'h0000, v[15:0]}, {16'h0000, val + 16'h0001});
            armed1_is(1'b0);
            pulse();
            cnt_is(val + 16'h0001);
            cmd(8'h21);
            pulse();
            cnt_is(val + 16'h0002);
        end
        $display("test counter done");
        // counter one at terminal count: deferred disarm, load ends it, modes
        u_host.wr(tcd_pkg::REG_STAT, {16'h0000, 16'h0001});
        cmd(8'h61);
        cmd(8'hf1);
        rd(tcd_pkg::REG_STAT);
        chk({31'h0, v[5]}, 32'h1);
        cmd(8'hc1);
        armed1_is(1'b1);
        pulse();
        cnt_is(16'hffff);
        armed1_is(1'b0);
        pulse();
        cnt_is(16'hffff);
        cmd(8'h41);
        cmd(8'hf1);
        cmd(8'h41);
        cnt_is(16'h0001);
        rd(tcd_pkg::REG_STAT);
        chk({31'h0, v[5]}, 32'h0);
        // disarm-on-terminal-count mode, then re-armed by load-and-arm
        u_host.wr(tcd_pkg::REG_STAT, {16'h0020, 16'h0001});
        cmd(8'h61);
        pulse();
        armed1_is(1'b0);
        cmd(8'h61);
        armed1_is(1'b1);
        pulse();
        cnt_is(16'h0000);
        // alternating mode: after load-and-arm the next source is the hold register
        u_host.wr(tcd_pkg::REG_STAT, {16'h8000, 16'h0005});
        cmd(8'h61);
        cnt_is(16'h0005);
        cmd(8'h41);
        cnt_is(val + 16'h0001);
        $display("test terminal count done");
        close_out();
    end
endmodule : tb
`default_nettype wire
